// *** design/clock_gen_pkg.sv ***
package clock_gen_pkg;

	// ==========================================================
	// Bus shape
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              write;
		logic              read;
	} reg_req_t;

	typedef struct packed {
		logic out;
		logic oe;
	} pin_drive_t;

	typedef enum {FAST_OFF, FAST_START, FAST_STABILIZE, FAST_RUN} fast_state_t;

	// ==========================================================
	// Register map
	localparam logic [ADDR_W-1:0] PORT2_OUTPUT_DATA_ADDR          = 16'hf210;
	localparam logic [ADDR_W-1:0] PORT2_STATE_MODE_LOW_ADDR       = 16'hf212;
	localparam logic [ADDR_W-1:0] PORT2_STATE_MODE_HIGH_ADDR      = 16'hf213;
	localparam logic [ADDR_W-1:0] PORT2_FUNCTION_SELECT_ADDR      = 16'hf214;
	localparam logic [ADDR_W-1:0] PORT3_OUTPUT_DATA_ADDR          = 16'hf218;
	localparam logic [ADDR_W-1:0] PORT3_DIRECTION_ADDR            = 16'hf219;
	localparam logic [ADDR_W-1:0] PORT3_STATE_MODE_HIGH_ADDR      = 16'hf21a;
	localparam logic [ADDR_W-1:0] PORT3_STATE_MODE_LOW_ADDR       = 16'hf21b;
	localparam logic [ADDR_W-1:0] PORT3_FUNCTION_SELECT_LOW_ADDR  = 16'hf21c;
	localparam logic [ADDR_W-1:0] PORT3_FUNCTION_SELECT_HIGH_ADDR = 16'hf21d;
	localparam logic [ADDR_W-1:0] FREQUENCY_CONTROL_0_ADDR        = 16'hf002;
	localparam logic [ADDR_W-1:0] FREQUENCY_CONTROL_1_ADDR        = 16'hf003;
	localparam logic [ADDR_W-1:0] FAST_BACKUP_ADDR                = 16'hf005;
	localparam logic [ADDR_W-1:0] FAST_STATUS_ADDR                = 16'hf007;

	localparam int PORT_REG_COUNT = 10;
	localparam logic [3:0] P2_DATA_IDX = 4'h0;
	localparam logic [3:0] P2_SLOW_IDX = 4'h1;
	localparam logic [3:0] P2_SHIGH_IDX = 4'h2;
	localparam logic [3:0] P2_FUNC_IDX = 4'h3;
	localparam logic [3:0] P3_DATA_IDX = 4'h4;
	localparam logic [3:0] P3_DIR_IDX = 4'h5;
	localparam logic [3:0] P3_SHIGH_IDX = 4'h6;
	localparam logic [3:0] P3_SLOW_IDX = 4'h7;
	localparam logic [3:0] P3_FLOW_IDX = 4'h8;
	localparam logic [3:0] P3_FHIGH_IDX = 4'h9;

	// Field positions
	localparam int MODE_BIT0_POS     = 0;
	localparam int MODE_BIT1_POS     = 1;
	localparam int OSC_ENABLE_POS    = 0;
	localparam int SYS_SELECT_POS    = 1;
	localparam int BACKUP_FLAG_POS   = 1;
	localparam int ST_RUNNING_POS    = 0;
	localparam int ST_SOURCE_PLL_POS = 1;
	localparam int ST_STOPPED_POS    = 2;
	localparam int ST_RESET_POS      = 3;
	localparam int ST_HOLD_POS       = 4;
	localparam int PIN20_POS         = 0;
	localparam int PIN21_POS         = 1;
	localparam int PIN36_POS         = 6;

	// Reset values: RC source, oscillator on, fast clock selected
	localparam logic [DATA_W-1:0] FREQUENCY_CONTROL_0_RESET = 8'h00;
	localparam logic [DATA_W-1:0] FREQUENCY_CONTROL_1_RESET = 8'h03;
	localparam logic [DATA_W-1:0] PORT_RESET                = 8'h00;

	// ==========================================================
	// Counts and times
	localparam int RC_STABLE_COUNT    = 16;
	localparam int PLL_ENABLE_COUNT   = 8192;
	localparam int PLL_STOP_COUNT     = 4096;
	localparam int POR_STABLE_COUNT   = 32768;
	localparam logic [15:0] RC_STABLE_LAST  = 16'(RC_STABLE_COUNT - 1);
	localparam logic [15:0] PLL_ENABLE_LAST = 16'(PLL_ENABLE_COUNT - 1);
	localparam logic [15:0] PLL_STOP_LAST   = 16'(PLL_STOP_COUNT - 1);
	localparam logic [15:0] POR_STABLE_LAST = 16'(POR_STABLE_COUNT - 1);

	localparam int CLOCK_MHZ              = 100;
	localparam int FAST_START_TIME_NS     = 1000;
	localparam int EXTERNAL_START_TIME_NS = 1000;
	localparam int FAST_START_CYCLES      = (FAST_START_TIME_NS * CLOCK_MHZ + 999) / 1000;
	localparam int EXTERNAL_START_CYCLES  = (EXTERNAL_START_TIME_NS * CLOCK_MHZ + 999) / 1000;
	localparam int SWITCH_WAIT_TIME_NS    = 10000;
	localparam int PLL_MULTIPLIER         = 500;
	localparam int PLL_FREQ_KHZ           = 16000;
	localparam int RC_FREQ_KHZ            = 2097;

endpackage

// *** design/high_speed_clock_and_system_clock_select_switch.sv ***
`timescale 1ns/1ns
`default_nettype none
module high_speed_clock_and_system_clock_select_switch
	import clock_gen_pkg::*;
#(
	parameter int START_CYCLES     = clock_gen_pkg::FAST_START_CYCLES,
	parameter int EXT_START_CYCLES = clock_gen_pkg::EXTERNAL_START_CYCLES,
	parameter int POR_COUNT        = clock_gen_pkg::POR_STABLE_COUNT
) (
	input  wire logic                      clock,
	input  wire logic                      rst_n,
	input  wire clock_gen_pkg::reg_req_t   reg_req,
	output logic [clock_gen_pkg::DATA_W-1:0] read_data,
	input  wire logic                      rc_osc_clock,
	input  wire logic                      pll_osc_clock,
	input  wire logic                      slow_clock,
	input  wire logic                      crystal_option,
	input  wire logic                      stop_request,
	input  wire logic                      stop_release,
	input  wire logic                      slow_clock_ready,
	output logic                           rc_osc_enable,
	output logic                           pll_enable,
	output logic                           fast_clock,
	output logic                           system_clock,
	output logic                           system_reset_active,
	output logic                           cpu_hold,
	output clock_gen_pkg::pin_drive_t      pin20,
	output clock_gen_pkg::pin_drive_t      pin21,
	output clock_gen_pkg::pin_drive_t      pin36
);
	import clock_gen_pkg::*;

	// ==========================================================
	// Oscillator sampling
	localparam int SRC_RC   = 0;
	localparam int SRC_PLL  = 1;
	localparam int SRC_SLOW = 2;

	logic [2:0] raw_osc;
	logic [2:0] stage [3];
	logic [2:0] osc_level;
	logic [2:0] osc_rise;

	assign raw_osc = {slow_clock, pll_osc_clock, rc_osc_clock};

	// Third stage filters the metastable-prone second stage
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sample
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					stage[gi] <= 3'h0;
				end else begin
					stage[gi] <= {stage[gi][1:0], raw_osc[gi]};
				end
			end
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					osc_level[gi] <= 1'b0;
				end else if (stage[gi][1] == stage[gi][2]) begin
					osc_level[gi] <= stage[gi][2];
				end
			end
			assign osc_rise[gi] = !osc_level[gi] && stage[gi][1] && stage[gi][2];
		end
	endgenerate

	// ==========================================================
	// Register file
	function automatic logic [4:0] port_decode(input logic [ADDR_W-1:0] a);
		logic [4:0] r;
		r = 5'h00;
		if (a == PORT2_OUTPUT_DATA_ADDR) begin
			r = {1'b1, P2_DATA_IDX};
		end else if (a == PORT2_STATE_MODE_LOW_ADDR) begin
			r = {1'b1, P2_SLOW_IDX};
		end else if (a == PORT2_STATE_MODE_HIGH_ADDR) begin
			r = {1'b1, P2_SHIGH_IDX};
		end else if (a == PORT2_FUNCTION_SELECT_ADDR) begin
			r = {1'b1, P2_FUNC_IDX};
		end else if (a == PORT3_OUTPUT_DATA_ADDR) begin
			r = {1'b1, P3_DATA_IDX};
		end else if (a == PORT3_DIRECTION_ADDR) begin
			r = {1'b1, P3_DIR_IDX};
		end else if (a == PORT3_STATE_MODE_HIGH_ADDR) begin
			r = {1'b1, P3_SHIGH_IDX};
		end else if (a == PORT3_STATE_MODE_LOW_ADDR) begin
			r = {1'b1, P3_SLOW_IDX};
		end else if (a == PORT3_FUNCTION_SELECT_LOW_ADDR) begin
			r = {1'b1, P3_FLOW_IDX};
		end else if (a == PORT3_FUNCTION_SELECT_HIGH_ADDR) begin
			r = {1'b1, P3_FHIGH_IDX};
		end
		return r;
	endfunction

	logic [DATA_W-1:0] port_reg [PORT_REG_COUNT];
	logic [DATA_W-1:0] frequency_control_0;
	logic [DATA_W-1:0] frequency_control_1;
	logic              fast_backup_flag;
	logic [4:0]        wr_port;
	logic [4:0]        rd_port;

	assign wr_port = port_decode(reg_req.addr);
	assign rd_port = wr_port;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < PORT_REG_COUNT; i++) begin
				port_reg[i] <= PORT_RESET;
			end
		end else if (reg_req.write && wr_port[4]) begin
			port_reg[wr_port[3:0]] <= reg_req.wdata;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			frequency_control_0 <= FREQUENCY_CONTROL_0_RESET;
			frequency_control_1 <= FREQUENCY_CONTROL_1_RESET;
		end else if (reg_req.write) begin
			if (reg_req.addr == FREQUENCY_CONTROL_0_ADDR) begin
				frequency_control_0 <= reg_req.wdata;
			end else if (reg_req.addr == FREQUENCY_CONTROL_1_ADDR) begin
				frequency_control_1 <= reg_req.wdata;
			end
		end
	end

	logic mode_pll;
	logic osc_enable;
	logic want_fast;
	logic backup_allowed;

	assign mode_pll       = !frequency_control_0[MODE_BIT0_POS] && frequency_control_0[MODE_BIT1_POS];
	assign osc_enable     = frequency_control_1[OSC_ENABLE_POS];
	assign want_fast      = frequency_control_1[SYS_SELECT_POS];
	assign backup_allowed = crystal_option && mode_pll;

	// ==========================================================
	// Fast clock sequencer
	localparam logic [15:0] POR_LAST = 16'(POR_COUNT - 1);

	fast_state_t state;
	logic [15:0] timer;
	logic [15:0] start_last;
	logic [15:0] stab_count;
	logic [15:0] stab_last;
	logic        use_pll;
	logic        stopped;
	logic        fast_running;
	logic        backup_set;
	logic        backup_cancel;
	logic        count_edge;

	assign fast_running  = (state == FAST_RUN);
	assign backup_set    = (state == FAST_OFF) && stopped && stop_release && osc_enable && backup_allowed;
	assign backup_cancel = reg_req.write && (reg_req.addr == FAST_BACKUP_ADDR)
		&& reg_req.wdata[BACKUP_FLAG_POS] && fast_backup_flag;
	assign count_edge    = use_pll ? osc_rise[SRC_PLL] : osc_rise[SRC_RC];

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state      <= FAST_START;
			timer      <= 16'h0000;
			start_last <= 16'(START_CYCLES - 1);
			stab_count <= 16'h0000;
			stab_last  <= POR_LAST;
			use_pll    <= 1'b0;
			stopped    <= 1'b0;
		end else if (stop_request) begin
			state   <= FAST_OFF;
			stopped <= 1'b1;
		end else if (!osc_enable && state != FAST_OFF) begin
			state <= FAST_OFF;
		end else begin
			case (state)
				FAST_OFF: begin
					timer      <= 16'h0000;
					stab_count <= 16'h0000;
					if (stopped && stop_release) begin
						stopped <= 1'b0;
						if (osc_enable) begin
							state <= FAST_START;
							if (backup_allowed) begin
								use_pll    <= 1'b0;
								stab_last  <= RC_STABLE_LAST;
								start_last <= 16'(START_CYCLES - 1);
							end else if (mode_pll) begin
								use_pll    <= 1'b1;
								stab_last  <= PLL_STOP_LAST;
								start_last <= 16'(EXT_START_CYCLES - 1);
							end else begin
								use_pll    <= 1'b0;
								stab_last  <= RC_STABLE_LAST;
								start_last <= 16'(START_CYCLES - 1);
							end
						end
					end else if (!stopped && osc_enable) begin
						state      <= FAST_START;
						use_pll    <= mode_pll;
						stab_last  <= mode_pll ? PLL_ENABLE_LAST : RC_STABLE_LAST;
						start_last <= mode_pll ? 16'(EXT_START_CYCLES - 1) : 16'(START_CYCLES - 1);
					end
				end
				FAST_START: begin
					if (timer == start_last) begin
						state <= FAST_STABILIZE;
					end else begin
						timer <= timer + 16'h0001;
					end
				end
				FAST_STABILIZE: begin
					if (count_edge) begin
						if (stab_count == stab_last) begin
							state <= FAST_RUN;
						end else begin
							stab_count <= stab_count + 16'h0001;
						end
					end
				end
				FAST_RUN: begin
					if (backup_cancel && !backup_set) begin
						use_pll <= 1'b1;
					end
				end
				default: begin
					state <= FAST_OFF;
				end
			endcase
		end
	end

	// Set wins over the software cancel
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fast_backup_flag <= 1'b0;
		end else if (backup_set) begin
			fast_backup_flag <= 1'b1;
		end else if (backup_cancel) begin
			fast_backup_flag <= 1'b0;
		end
	end

	// PLL keeps running during backup so a cancel finds it warm
	assign pll_enable    = (state != FAST_OFF) && (use_pll || fast_backup_flag);
	assign rc_osc_enable = (state != FAST_OFF) && !use_pll;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fast_clock <= 1'b0;
		end else begin
			fast_clock <= fast_running && (use_pll ? osc_level[SRC_PLL] : osc_level[SRC_RC]);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			system_reset_active <= 1'b1;
		end else if (fast_running) begin
			system_reset_active <= 1'b0;
		end
	end

	// ==========================================================
	// System clock switch
	logic sys_sel;
	logic target_ready;

	assign target_ready = want_fast ? fast_running : slow_clock_ready;

	// Swap only while both sources sit low, so no pulse is cut short
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sys_sel <= 1'b1;
		end else if (sys_sel != want_fast && target_ready && !fast_clock && !osc_level[SRC_SLOW]) begin
			sys_sel <= want_fast;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			system_clock <= 1'b0;
		end else begin
			system_clock <= sys_sel ? fast_clock : osc_level[SRC_SLOW];
		end
	end

	assign cpu_hold = (sys_sel != want_fast) || (sys_sel ? !fast_running : !slow_clock_ready);

	// ==========================================================
	// Clock output pins
	logic p21_clk;
	logic p20_clk;
	logic p36_clk;
	logic p21_cmos;
	logic p20_cmos;
	logic p36_cmos;

	assign p21_cmos = port_reg[P2_SHIGH_IDX][PIN21_POS] && port_reg[P2_SLOW_IDX][PIN21_POS];
	assign p20_cmos = port_reg[P2_SHIGH_IDX][PIN20_POS] && port_reg[P2_SLOW_IDX][PIN20_POS];
	assign p36_cmos = port_reg[P3_SHIGH_IDX][PIN36_POS] && port_reg[P3_SLOW_IDX][PIN36_POS];
	assign p21_clk  = port_reg[P2_FUNC_IDX][PIN21_POS] && p21_cmos;
	assign p20_clk  = port_reg[P2_FUNC_IDX][PIN20_POS] && p20_cmos;
	assign p36_clk  = !port_reg[P3_FHIGH_IDX][PIN36_POS] && port_reg[P3_FLOW_IDX][PIN36_POS]
		&& p36_cmos && !port_reg[P3_DIR_IDX][PIN36_POS];

	// Port 2 pins have no direction bit; CMOS state alone drives them
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pin21 <= '0;
			pin20 <= '0;
			pin36 <= '0;
		end else begin
			pin21.out <= p21_clk ? fast_clock : port_reg[P2_DATA_IDX][PIN21_POS];
			pin21.oe  <= p21_cmos;
			pin20.out <= p20_clk ? osc_level[SRC_SLOW] : port_reg[P2_DATA_IDX][PIN20_POS];
			pin20.oe  <= p20_cmos;
			pin36.out <= p36_clk ? osc_level[SRC_SLOW] : port_reg[P3_DATA_IDX][PIN36_POS];
			pin36.oe  <= p36_cmos && !port_reg[P3_DIR_IDX][PIN36_POS];
		end
	end

	// ==========================================================
	// Read path
	logic [DATA_W-1:0] status;

	assign status = {3'h0, cpu_hold, system_reset_active, stopped, use_pll, fast_running};

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			read_data <= '0;
		end else if (!reg_req.read) begin
			read_data <= '0;
		end else if (rd_port[4]) begin
			read_data <= port_reg[rd_port[3:0]];
		end else if (reg_req.addr == FREQUENCY_CONTROL_0_ADDR) begin
			read_data <= frequency_control_0;
		end else if (reg_req.addr == FREQUENCY_CONTROL_1_ADDR) begin
			read_data <= frequency_control_1;
		end else if (reg_req.addr == FAST_BACKUP_ADDR) begin
			read_data <= 8'(fast_backup_flag) << BACKUP_FLAG_POS;
		end else if (reg_req.addr == FAST_STATUS_ADDR) begin
			read_data <= status;
		end else begin
			read_data <= '0;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence stop_entered;
		stop_request ##1 (state == FAST_OFF);
	endsequence

	sequence crystal_release;
		(state == FAST_OFF) && stopped && stop_release && osc_enable && backup_allowed;
	endsequence

	rc_after_reset_a: assert property ((system_reset_active && state != FAST_OFF) |-> !use_pll)
		else $error("fast source not RC during power-on");
	stab_count_done_a: assert property ($rose(fast_running) |-> $past(stab_count) == $past(stab_last))
		else $error("fast clock delivered before stabilization count");
	por_release_a: assert property ($fell(system_reset_active) |-> $past(fast_running)
		&& $past(stab_last) == POR_LAST)
		else $error("system reset released early");
	stop_halts_a: assert property (stop_entered |-> !rc_osc_enable && !pll_enable ##1 !fast_clock)
		else $error("oscillator still enabled in STOP");
	backup_set_a: assert property (crystal_release |=> fast_backup_flag && !use_pll
		&& stab_last == RC_STABLE_LAST)
		else $error("RC backup not taken after STOP release");
	backup_gate_a: assert property ($rose(fast_backup_flag) |-> $past(backup_allowed))
		else $error("backup entered without crystal and PLL");
	backup_cancel_a: assert property ((backup_cancel && !backup_set) |=> !fast_backup_flag)
		else $error("backup flag not cleared by write of one");
	hold_fast_a: assert property ((want_fast && !fast_running) |-> cpu_hold)
		else $error("CPU not held while fast clock absent");
	glitch_free_a: assert property ($changed(sys_sel) |-> $past(fast_clock) == 1'b0
		&& $past(osc_level[SRC_SLOW]) == 1'b0)
		else $error("system clock switched on a high level");
	stop_counts_a: assert property ((state == FAST_OFF && stopped && stop_release && osc_enable
		&& !backup_allowed && mode_pll) |=> stab_last == PLL_STOP_LAST)
		else $error("wrong stabilization count after STOP");

endmodule
`default_nettype wire

// *** tb/osc_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module osc_model (
	input  wire logic clock,
	input  wire logic rc_osc_enable,
	input  wire logic pll_enable,
	output logic      rc_osc_clock,
	output logic      pll_osc_clock,
	output logic      slow_clock,
	output logic      slow_clock_ready
);
	// ==========================================================
	// Oscillators
	// Half period of 3 clocks, one above the 2 the sampling filter still counts; keeps POR short
	logic [1:0] rc_div   = 2'h0;
	logic [1:0] pll_div  = 2'h0;
	logic [3:0] slow_div = 4'h0;
	logic [4:0] up_count = 5'h0;
	logic       rc_lvl   = 1'b0;
	logic       pll_lvl  = 1'b0;
	logic       slow_lvl = 1'b0;
	// Disabled oscillators stand still low, as a real one stops
	always_ff @(posedge clock) begin
		rc_div <= (!rc_osc_enable || rc_div == 2'h2) ? 2'h0 : rc_div + 2'h1;
		rc_lvl <= !rc_osc_enable ? 1'b0 : (rc_div == 2'h2 ? !rc_lvl : rc_lvl);
	end
	always_ff @(posedge clock) begin
		pll_div <= (!pll_enable || pll_div == 2'h2) ? 2'h0 : pll_div + 2'h1;
		pll_lvl <= !pll_enable ? 1'b0 : (pll_div == 2'h2 ? !pll_lvl : pll_lvl);
	end
	always_ff @(posedge clock) begin
		slow_div <= (slow_div == 4'h9) ? 4'h0 : slow_div + 4'h1;
		slow_lvl <= (slow_div == 4'h9) ? !slow_lvl : slow_lvl;
		up_count <= (up_count == 5'h1f) ? up_count : up_count + 5'h1;
	end
	assign rc_osc_clock     = rc_lvl;
	assign pll_osc_clock    = pll_lvl;
	assign slow_clock       = slow_lvl;
	assign slow_clock_ready = (up_count == 5'h1f);
endmodule
`default_nettype wire

// *** tb/high_speed_clock_and_system_clock_select_switch_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module high_speed_clock_and_system_clock_select_switch_bench;
	import clock_gen_pkg::*;
	localparam int LIMIT = 90000;
	// Shortened power-on count keeps the run within budget
	localparam int POR_N = 256;
	localparam logic [15:0] PREG[10] = '{PORT2_OUTPUT_DATA_ADDR, PORT2_STATE_MODE_LOW_ADDR,
		PORT2_STATE_MODE_HIGH_ADDR, PORT2_FUNCTION_SELECT_ADDR, PORT3_OUTPUT_DATA_ADDR,
		PORT3_DIRECTION_ADDR, PORT3_STATE_MODE_HIGH_ADDR, PORT3_STATE_MODE_LOW_ADDR,
		PORT3_FUNCTION_SELECT_LOW_ADDR, PORT3_FUNCTION_SELECT_HIGH_ADDR};
	logic clock = 1'b0;
	logic rst_n;
	reg_req_t reg_req;
	logic [7:0] read_data;
	logic rc_osc_clock, pll_osc_clock, slow_clock, slow_clock_ready;
	logic crystal_option, stop_request, stop_release;
	logic rc_osc_enable, pll_enable, fast_clock, system_clock, system_reset_active, cpu_hold;
	pin_drive_t pin20, pin21, pin36;
	int cycle_count = 0;
	int num_errors = 0;
	int total_checks = 0;
	int t0;
	logic [7:0] d;

	always #5 clock = !clock;

	high_speed_clock_and_system_clock_select_switch #(.START_CYCLES(2), .EXT_START_CYCLES(2), .POR_COUNT(POR_N)) uut (
		.clock(clock), .rst_n(rst_n), .reg_req(reg_req), .read_data(read_data),
		.rc_osc_clock(rc_osc_clock), .pll_osc_clock(pll_osc_clock), .slow_clock(slow_clock),
		.crystal_option(crystal_option), .stop_request(stop_request), .stop_release(stop_release),
		.slow_clock_ready(slow_clock_ready), .rc_osc_enable(rc_osc_enable), .pll_enable(pll_enable),
		.fast_clock(fast_clock), .system_clock(system_clock),
		.system_reset_active(system_reset_active), .cpu_hold(cpu_hold),
		.pin20(pin20), .pin21(pin21), .pin36(pin36));

	osc_model osc (.clock(clock), .rc_osc_enable(rc_osc_enable), .pll_enable(pll_enable),
		.rc_osc_clock(rc_osc_clock), .pll_osc_clock(pll_osc_clock), .slow_clock(slow_clock),
		.slow_clock_ready(slow_clock_ready));

	// ==========================================================
	// Bus and compare tasks
	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_req <= '{a, v, 1'b1, 1'b0};
		@(posedge clock);
		reg_req.write <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge clock);
		reg_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clock);
		reg_req.read <= 1'b0;
		#1 v = read_data;
	endtask

	task automatic chk_rd(input string name, input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		check(name, v & m, e);
	endtask

	// Result is {oe held, out seen high, out seen low} over 60 cycles
	task automatic pin_watch(input int which, input logic [7:0] e, input string name);
		pin_drive_t p;
		logic [2:0] r;
		r = 3'b100;
		repeat (60) begin
			@(posedge clock);
			#1 p = (which == 0) ? pin20 : (which == 1) ? pin21 : (which == 2) ? pin36
				: pin_drive_t'({system_clock, 1'b1});
			r = r & {p.oe, 2'b11} | {1'b0, p.out === 1'b1, p.out === 1'b0};
		end
		check(name, {5'h0, r}, e);
	endtask

	task automatic wait_running(output int n);
		logic [7:0] v;
		t0 = cycle_count;
		v = 8'h00;
		while (v[ST_RUNNING_POS] !== 1'b1 && cycle_count < t0 + 60000) rd(FAST_STATUS_ADDR, v);
		if (v[ST_RUNNING_POS] !== 1'b1) num_errors++;
		n = cycle_count - t0;
	endtask

	task automatic stop_and_release(output int n);
		@(posedge clock) stop_request <= 1'b1;
		@(posedge clock) stop_request <= 1'b0;
		repeat (5) @(posedge clock);
		@(posedge clock) stop_release <= 1'b1;
		@(posedge clock) stop_release <= 1'b0;
		wait_running(n);
	endtask

	always @(posedge clock) begin
		cycle_count <= cycle_count + 1;
		if (cycle_count == LIMIT) begin
			num_errors++;
			final_report();
		end
	end

	// ==========================================================
	// Tests
	initial begin
		int n;
		rst_n = 1'b0;
		reg_req = '0;
		crystal_option = 1'b1;
		stop_request = 1'b0;
		stop_release = 1'b0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		chk_rd("fc0", FREQUENCY_CONTROL_0_ADDR, 8'hff, 8'h00);
		chk_rd("fc1", FREQUENCY_CONTROL_1_ADDR, 8'hff, 8'h03);
		check("sys_reset", {7'h0, system_reset_active}, 8'h01);
		t0 = cycle_count;
		while (system_reset_active === 1'b1 && cycle_count < t0 + 5000) @(posedge clock);
		check("por_wait", {7'h0, cycle_count - t0 >= (POR_N - 1) * 6}, 8'h01);
		chk_rd("status_run", FAST_STATUS_ADDR, 8'h0f, 8'h01);
		for (int i = 0; i < 10; i++) chk_rd("port_rst", PREG[i], 8'hff, 8'h00);
		for (int i = 0; i < 10; i++) wr(PREG[i], 8'(8'h11 * (i + 1)));
		for (int i = 0; i < 10; i++) chk_rd("port_rw", PREG[i], 8'hff, 8'(8'h11 * (i + 1)));
		chk_rd("unmapped", 16'hf0ff, 8'hff, 8'h00);
		// Port 2: fast clock out on bit 1, data bit 1 set and ignored
		wr(PREG[2], 8'h03);
		wr(PREG[1], 8'h03);
		wr(PREG[0], 8'h02);
		wr(PREG[3], 8'h02);
		pin_watch(1, 8'h07, "pin21_clk");
		pin_watch(0, 8'h05, "pin20_data");
		wr(PREG[3], 8'h03);
		pin_watch(0, 8'h07, "pin20_clk");
		// Port 3: slow clock out on bit 6 only once direction is output
		wr(PREG[8], 8'h40);
		wr(PREG[9], 8'h00);
		wr(PREG[6], 8'h40);
		wr(PREG[7], 8'h40);
		wr(PREG[4], 8'h00);
		wr(PREG[5], 8'h40);
		pin_watch(2, 8'h01, "pin36_input");
		wr(PREG[5], 8'h00);
		pin_watch(2, 8'h07, "pin36_clk");
		wr(PREG[9], 8'h40);
		pin_watch(2, 8'h05, "pin36_port");
		// PLL, fast clock selected before it runs
		wr(FREQUENCY_CONTROL_1_ADDR, 8'h00);
		pin_watch(3, 8'h07, "system_clock_select_slow");
		check("hold_slow", {7'h0, cpu_hold}, 8'h00);
		wr(FREQUENCY_CONTROL_0_ADDR, 8'h02);
		wr(FREQUENCY_CONTROL_1_ADDR, 8'h03);
		repeat (4) @(posedge clock);
		#1 check("hold_early", {7'h0, cpu_hold}, 8'h01);
		wait_running(n);
		check("pll_wait", {7'h0, n >= 8191 * 6}, 8'h01);
		chk_rd("src_pll", FAST_STATUS_ADDR, 8'h03, 8'h03);
		repeat (20) @(posedge clock);
		#1 check("hold_free", {7'h0, cpu_hold}, 8'h00);
		pin_watch(3, 8'h07, "system_clock_select_fast");
		// STOP and release with crystal option: RC backup
		@(posedge clock) stop_request <= 1'b1;
		@(posedge clock) stop_request <= 1'b0;
		repeat (5) @(posedge clock);
		#1 check("stopped", {5'h0, rc_osc_enable, pll_enable, fast_clock}, 8'h00);
		chk_rd("st_stop", FAST_STATUS_ADDR, 8'h05, 8'h04);
		@(posedge clock) stop_release <= 1'b1;
		@(posedge clock) stop_release <= 1'b0;
		wait_running(n);
		check("rel_wait", {7'h0, n < 2000}, 8'h01);
		chk_rd("backup_set", FAST_BACKUP_ADDR, 8'h02, 8'h02);
		wr(FAST_BACKUP_ADDR, 8'h00);
		chk_rd("backup_w0", FAST_BACKUP_ADDR, 8'h02, 8'h02);
		wr(FAST_BACKUP_ADDR, 8'h02);
		chk_rd("backup_w1", FAST_BACKUP_ADDR, 8'h02, 8'h00);
		chk_rd("back_pll", FAST_STATUS_ADDR, 8'h02, 8'h02);
		// STOP release in PLL mode without crystal: PLL count, no backup
		@(posedge clock) crystal_option <= 1'b0;
		stop_and_release(n);
		check("pll_rel_wait", {7'h0, n >= (PLL_STOP_COUNT - 1) * 6}, 8'h01);
		chk_rd("pll_rel_src", FAST_STATUS_ADDR, 8'h02, 8'h02);
		chk_rd("no_backup", FAST_BACKUP_ADDR, 8'h02, 8'h00);
		// RC chosen by software: no backup even with crystal
		@(posedge clock) crystal_option <= 1'b1;
		wr(FREQUENCY_CONTROL_0_ADDR, 8'h00);
		stop_and_release(n);
		check("rc_rel_wait", {7'h0, n >= (RC_STABLE_COUNT - 1) * 6 && n < 2000}, 8'h01);
		chk_rd("rc_rel_src", FAST_STATUS_ADDR, 8'h02, 8'h00);
		chk_rd("rc_no_backup", FAST_BACKUP_ADDR, 8'h02, 8'h00);
		final_report();
	end
endmodule
`default_nettype wire
